// ---- rtl/scof_core.v ----
`timescale 1ns/100ps
`include "scof_map.vh"

module scof_core (
   // clock and reset
   input  wire       clk,
   input  wire       srst,
   // loop inputs
   input  wire       reference_in,
   input  wire       loop_feedback_in,
   input  wire [1:0] frequency_range_select,
   // select straps
   input  wire [1:0] pair1_select_lo,
   input  wire [1:0] pair1_select_hi,
   input  wire [1:0] pair2_select_lo,
   input  wire [1:0] pair2_select_hi,
   input  wire [1:0] pair3_select_lo,
   input  wire [1:0] pair3_select_hi,
   input  wire [1:0] pair4_select_lo,
   input  wire [1:0] pair4_select_hi,
   // output pairs
   output wire       pair1_out_a,
   output wire       pair1_out_b,
   output wire       pair2_out_a,
   output wire       pair2_out_b,
   output wire       pair3_out_a,
   output wire       pair3_out_b,
   output wire       pair4_out_a,
   output wire       pair4_out_b,
   // status
   output reg        loop_locked
);

   // ==========================================================
   // range decoding
   function [`SCOF_HP_W-1:0] hp_min;
      input [1:0] fs;
      begin
         case (fs)
            `SCOF_LVL_LOW:  hp_min = `SCOF_LOW_MIN;
            `SCOF_LVL_HIGH: hp_min = `SCOF_HIGH_MIN;
            default:        hp_min = `SCOF_MID_MIN;
         endcase
      end
   endfunction

   function [`SCOF_HP_W-1:0] hp_max;
      input [1:0] fs;
      begin
         case (fs)
            `SCOF_LVL_LOW:  hp_max = `SCOF_LOW_MAX;
            `SCOF_LVL_HIGH: hp_max = `SCOF_HIGH_MAX;
            default:        hp_max = `SCOF_MID_MAX;
         endcase
      end
   endfunction

   // ==========================================================
   // edge detection
   reg                    ref_d_r;
   reg                    fb_d_r;
   wire                   ref_rise = reference_in & ~ref_d_r;
   wire                   fb_rise  = loop_feedback_in & ~fb_d_r;

   // ==========================================================
   // period and phase measurement
   reg  [`SCOF_CNT_W-1:0] ref_cnt_r;
   reg  [`SCOF_CNT_W-1:0] fb_cnt_r;
   reg  [`SCOF_CNT_W-1:0] ref_per_r;
   reg  [`SCOF_CNT_W-1:0] fb_per_r;
   reg  [1:0]             ref_seen_r;
   reg  [1:0]             fb_seen_r;
   wire                   per_ok = ref_seen_r[1] & fb_seen_r[1];
   wire [`SCOF_CNT_W-1:0] fb_per_now  = fb_cnt_r + 16'h0001;
   wire [`SCOF_CNT_W-1:0] ref_half    = {1'b0, ref_per_r[`SCOF_CNT_W-1:1]};
   wire [`SCOF_CNT_W-1:0] fb_err      = ref_rise ? 16'h0000 : ref_cnt_r + 16'h0001;
   wire                   too_slow    = fb_per_now > ref_per_r + `SCOF_FREQ_TOL;
   wire                   too_fast    = fb_per_now + `SCOF_FREQ_TOL < ref_per_r;

   // edge history tracks the pins through reset, so release makes no false rise
   always @(posedge clk) begin
      ref_d_r <= reference_in;
      fb_d_r  <= loop_feedback_in;
   end

   always @(posedge clk) begin
      if (srst) begin
         ref_cnt_r  <= 16'h0000;
         fb_cnt_r   <= 16'h0000;
         ref_per_r  <= 16'h0000;
         fb_per_r   <= 16'h0000;
         ref_seen_r <= 2'h0;
         fb_seen_r  <= 2'h0;
      end else begin
         if (ref_rise) begin
            ref_cnt_r  <= 16'h0000;
            ref_per_r  <= ref_cnt_r + 16'h0001;
            ref_seen_r <= {ref_seen_r[0], 1'b1};
         end else if (ref_cnt_r != `SCOF_CNT_MAX) begin
            ref_cnt_r <= ref_cnt_r + 16'h0001;
         end
         if (fb_rise) begin
            fb_cnt_r  <= 16'h0000;
            fb_per_r  <= fb_per_now;
            fb_seen_r <= {fb_seen_r[0], 1'b1};
         end else if (fb_cnt_r != `SCOF_CNT_MAX) begin
            fb_cnt_r <= fb_cnt_r + 16'h0001;
         end
      end
   end

   // ==========================================================
   // internal oscillator
   // a bang-bang loop: one clk of phase or one step of half-period per
   // feedback edge; it dithers by one cycle when the period is not exact
   reg  [`SCOF_HP_W-1:0]  hp_r;
   reg  [`SCOF_HP_W-1:0]  hp_nxt;
   reg  [`SCOF_HP_W-1:0]  ph_cnt_r;
   reg                    osc_r;
   reg                    adv_r;
   reg                    ret_r;
   reg                    adv_nxt;
   reg                    ret_nxt;
   wire [`SCOF_HP_W-1:0]  lo_b = hp_min(frequency_range_select);
   wire [`SCOF_HP_W-1:0]  hi_b = hp_max(frequency_range_select);
   wire [`SCOF_HP_W-1:0]  hp_end = hp_r - (adv_r ? 6'h02 : 6'h01) + (ret_r ? 6'h01 : 6'h00);
   wire                   half_done = (ph_cnt_r >= hp_end);

   always @* begin
      hp_nxt  = hp_r;
      adv_nxt = adv_r & ~half_done;
      ret_nxt = ret_r & ~half_done;
      if (fb_rise && per_ok) begin
         // divided feedback slows, so speed up
         if (too_slow)
            hp_nxt = hp_r - 6'h01;
         else if (too_fast)
            hp_nxt = hp_r + 6'h01;
         // align feedback rise to reference rise
         else if (fb_err != 16'h0000 && fb_err <= ref_half)
            adv_nxt = 1'b1;
         else if (fb_err > ref_half)
            ret_nxt = 1'b1;
      end
      if (hp_nxt < lo_b)
         hp_nxt = lo_b;
      else if (hp_nxt > hi_b)
         hp_nxt = hi_b;
   end

   always @(posedge clk) begin
      if (srst) begin
         hp_r     <= `SCOF_HP_RST;
         ph_cnt_r <= 6'h00;
         osc_r    <= 1'b0;
         adv_r    <= 1'b0;
         ret_r    <= 1'b0;
      end else begin
         hp_r  <= hp_nxt;
         adv_r <= adv_nxt;
         ret_r <= ret_nxt;
         if (half_done) begin
            ph_cnt_r <= 6'h00;
            osc_r    <= ~osc_r;
         end else begin
            ph_cnt_r <= ph_cnt_r + 6'h01;
         end
      end
   end

   // ==========================================================
   // lock indication
   reg  [3:0]             lock_cnt_r;
   wire                   aligned = fb_rise & ref_rise;

   always @(posedge clk) begin
      if (srst) begin
         lock_cnt_r  <= 4'h0;
         loop_locked <= 1'b0;
      end else if (fb_rise) begin
         if (!aligned) begin
            lock_cnt_r  <= 4'h0;
            loop_locked <= 1'b0;
         end else if (lock_cnt_r == `SCOF_LOCK_EDGES) begin
            loop_locked <= 1'b1;
         end else begin
            lock_cnt_r <= lock_cnt_r + 4'h1;
         end
      end
   end

   // ==========================================================
   // skew delay line and dividers
   // the dividers step from tap 3 so their registered edges land with tap 4
   reg  [`SCOF_TAPS-1:0]  taps_r;
   reg  [1:0]             div_r;

   always @(posedge clk) begin
      if (srst) begin
         taps_r <= 9'h000;
         div_r  <= 2'h0;
      end else begin
         taps_r <= {taps_r[`SCOF_TAPS-2:0], osc_r};
         if (taps_r[3] & ~taps_r[4])
            div_r <= div_r + 2'h1;
      end
   end

   // ==========================================================
   // output pairs
   // straps feed decode directly each cycle
   wire [7:0] sel_lo_all = {pair4_select_lo, pair3_select_lo, pair2_select_lo, pair1_select_lo};
   wire [7:0] sel_hi_all = {pair4_select_hi, pair3_select_hi, pair2_select_hi, pair1_select_hi};
   wire [3:0] out_a_all;
   wire [3:0] out_b_all;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pair
         // each pair decodes on its own
         scof_pair #(
            .HAS_FUNC (gi >= 2)
         ) u_pair (
            .clk    (clk),
            .srst   (srst),
            .sel_lo (sel_lo_all[2*gi+1:2*gi]),
            .sel_hi (sel_hi_all[2*gi+1:2*gi]),
            .taps   (taps_r),
            .div2   (div_r[0]),
            .div4   (div_r[1]),
            .out_a  (out_a_all[gi]),
            .out_b  (out_b_all[gi])
         );
      end
   endgenerate

   // inversion relative to reference follows from the feedback choice
   assign pair1_out_a = out_a_all[0];
   assign pair1_out_b = out_b_all[0];
   assign pair2_out_a = out_a_all[1];
   assign pair2_out_b = out_b_all[1];
   assign pair3_out_a = out_a_all[2];
   assign pair3_out_b = out_b_all[2];
   assign pair4_out_a = out_a_all[3];
   assign pair4_out_b = out_b_all[3];

endmodule

// ---- inc/scof_map.vh ----
`ifndef SCOF_MAP_VH
`define SCOF_MAP_VH

// ==========================================================
// three-level strap encoding (open pin reads as mid)
`define SCOF_LVL_LOW     2'h0
`define SCOF_LVL_MID     2'h1
`define SCOF_LVL_HIGH    2'h2

// ==========================================================
// output function codes
`define SCOF_FN_SKEW     2'h0
`define SCOF_FN_INV      2'h1
`define SCOF_FN_DIV2     2'h2
`define SCOF_FN_DIV4     2'h3

// ==========================================================
// skew delay line, one skew unit per clock cycle
`define SCOF_TAPS        9
`define SCOF_TAP_ZERO    4'h4

// ==========================================================
// internal oscillator half-period in clk cycles, per range
`define SCOF_HP_W        6
`define SCOF_HP_RST      6'h10
`define SCOF_LOW_MIN     6'h10
`define SCOF_LOW_MAX     6'h20
`define SCOF_MID_MIN     6'h0a
`define SCOF_MID_MAX     6'h14
`define SCOF_HIGH_MIN    6'h06
`define SCOF_HIGH_MAX    6'h0c

// ==========================================================
// period measurement and lock
`define SCOF_CNT_W       16
`define SCOF_CNT_MAX     16'hffff
// below one period step, or the loop parks a step off and slips phase
`define SCOF_FREQ_TOL    16'h0001
`define SCOF_LOCK_EDGES  4'h8

`endif

// ---- rtl/scof_pair.v ----
`timescale 1ns/100ps
`include "scof_map.vh"

module scof_pair #(
   parameter HAS_FUNC = 1'b0
) (
   // clock and reset
   input  wire       clk,
   input  wire       srst,
   // select straps
   input  wire [1:0] sel_lo,
   input  wire [1:0] sel_hi,
   // delayed internal clock and dividers
   input  wire [8:0] taps,
   input  wire       div2,
   input  wire       div4,
   // output pair
   output reg        out_a,
   output reg        out_b
);

   // ==========================================================
   // strap decoding
   function [1:0] lvl;
      input [1:0] s;
      begin
         if (s == `SCOF_LVL_LOW)
            lvl = 2'h0;
         else if (s == `SCOF_LVL_HIGH)
            lvl = 2'h2;
         else
            lvl = 2'h1;
      end
   endfunction

   function [3:0] skew_tap;
      input [1:0] lo;
      input [1:0] hi;
      begin
         skew_tap = {2'h0, lvl(hi)} * 4'h3 + {2'h0, lvl(lo)};
      end
   endfunction

   wire [1:0] lo_l = lvl(sel_lo);
   wire [1:0] hi_l = lvl(sel_hi);
   reg  [1:0] fn;
   reg        out_nxt;

   // ==========================================================
   // function select and output
   always @* begin
      fn = `SCOF_FN_SKEW;
      if (HAS_FUNC) begin
         if (lo_l == 2'h2 && hi_l == 2'h2)
            fn = `SCOF_FN_INV;
         else if (lo_l == 2'h0 && hi_l == 2'h0)
            fn = `SCOF_FN_DIV2;
         else if (lo_l == 2'h2 && hi_l == 2'h0)
            fn = `SCOF_FN_DIV4;
      end
   end

   always @* begin
      case (fn)
         `SCOF_FN_SKEW: out_nxt = taps[skew_tap(sel_lo, sel_hi)];
         `SCOF_FN_INV:  out_nxt = ~taps[`SCOF_TAP_ZERO];
         `SCOF_FN_DIV2: out_nxt = div2;
         `SCOF_FN_DIV4: out_nxt = div4;
         default:       out_nxt = taps[`SCOF_TAP_ZERO];
      endcase
   end

   always @(posedge clk) begin
      if (srst) begin
         out_a <= 1'b0;
         out_b <= 1'b0;
      end else begin
         out_a <= out_nxt;
         out_b <= out_nxt;
      end
   end

endmodule

// ---- verif/scof_properties.sv ----
`timescale 1ns/100ps
`include "scof_map.vh"
// ====================
// pin checks on the core
module scof_properties (
   // clock and reset
   input wire       clk,
   input wire       srst,
   // loop inputs and straps
   input wire       reference_in,
   input wire       loop_feedback_in,
   input wire [1:0] frequency_range_select,
   input wire [1:0] pair1_select_lo,
   input wire [1:0] pair1_select_hi,
   input wire [1:0] pair2_select_lo,
   input wire [1:0] pair2_select_hi,
   input wire [1:0] pair3_select_lo,
   input wire [1:0] pair3_select_hi,
   input wire [1:0] pair4_select_lo,
   input wire [1:0] pair4_select_hi,
   // outputs
   input wire       pair1_out_a,
   input wire       pair1_out_b,
   input wire       pair2_out_a,
   input wire       pair2_out_b,
   input wire       pair3_out_a,
   input wire       pair3_out_b,
   input wire       pair4_out_a,
   input wire       pair4_out_b,
   input wire       loop_locked
);
   localparam [1:0] L = `SCOF_LVL_LOW;
   localparam [1:0] M = `SCOF_LVL_MID;
   localparam [1:0] H = `SCOF_LVL_HIGH;
   wire [3:0] s1 = {pair1_select_hi, pair1_select_lo};
   wire [3:0] s2 = {pair2_select_hi, pair2_select_lo};
   wire [3:0] s3 = {pair3_select_hi, pair3_select_lo};
   wire [3:0] s4 = {pair4_select_hi, pair4_select_lo};
   wire zz = s1 == {M, M} && s2 == {M, M};
   wire z3 = s1 == {M, M} && s3 == {M, M};
   wire inv = s1 == {M, M} && s4 == {H, H};
   wire dv = s3 == {L, H} && s4 == {L, L};
   logic [7:0] hi_len_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // high run of a true output; nudging may stretch or shorten it a cycle
   always_ff @(posedge clk) hi_len_r <= (srst || !pair1_out_a) ? 8'h0 : hi_len_r + 8'h1;
   sequence s_bad_rise;
      loop_locked && $rose(loop_feedback_in) && !$rose(reference_in);
   endsequence
   // ====================
   // assertions
   quiet_reset_a: assert property (srst |=> !pair1_out_a && !pair2_out_a && !pair3_out_a
      && !pair4_out_a && !loop_locked) else $error("outputs not quiet after reset");
   pair_match_a: assert property (pair1_out_a == pair1_out_b && pair2_out_a == pair2_out_b
      && pair3_out_a == pair3_out_b && pair4_out_a == pair4_out_b) else $error("pair split");
   zero_align_a: assert property (zz && $past(zz) |-> pair1_out_a == pair2_out_a)
      else $error("zero skew pairs apart");
   align_three_a: assert property (z3 && $past(z3) |-> pair1_out_a == pair3_out_a)
      else $error("pair three apart");
   inv_pair_a: assert property (!$past(srst) && !$past(srst, 2) && inv && $past(inv)
      |-> pair4_out_a != pair1_out_a) else $error("pair four not inverted");
   fall_together_a: assert property (dv && $past(dv) && $fell(pair3_out_a)
      |-> $fell(pair4_out_a)) else $error("divided outputs fall apart");
   low_range_a: assert property ($fell(pair1_out_a) && frequency_range_select == L
      |-> hi_len_r inside {[14:34]}) else $error("low range half period off");
   misalign_clear_a: assert property (s_bad_rise |-> ##[1:3] !loop_locked)
      else $error("lock kept on misaligned rise");
endmodule

// ---- verif/scof_board.sv ----
`timescale 1ns/100ps
// ====================
// board clock source and feedback trace
module scof_board (
   // bench clock and board setup
   input  wire       clk,
   input  wire [7:0] ref_hp,
   input  wire [1:0] fb_sel,
   // device outputs on the board
   input  wire [3:0] outs_a,
   // board to device
   output reg        reference_in,
   output wire       loop_feedback_in
);
   reg [7:0] cnt_r;
   initial begin
      reference_in = 1'b0;
      cnt_r = 8'h0;
   end
   always @(posedge clk) begin
      if (cnt_r >= ref_hp - 8'h1) begin
         cnt_r <= 8'h0;
         reference_in <= ~reference_in;
      end else begin
         cnt_r <= cnt_r + 8'h1;
      end
   end
   // one output trace wired back, no extra delay
   assign loop_feedback_in = outs_a[fb_sel];
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`include "scof_map.vh"
// ====================
// bench top: board model, core, pin checker
module testbench;
   logic        clk, srst, reference_in, loop_feedback_in, loop_locked;
   logic [1:0]  frequency_range_select, fb_sel;
   logic [1:0]  pair1_select_lo, pair1_select_hi, pair2_select_lo, pair2_select_hi;
   logic [1:0]  pair3_select_lo, pair3_select_hi, pair4_select_lo, pair4_select_hi;
   logic        pair1_out_a, pair1_out_b, pair2_out_a, pair2_out_b;
   logic        pair3_out_a, pair3_out_b, pair4_out_a, pair4_out_b;
   logic [15:0] straps;
   logic [7:0]  ref_hp;
   logic [31:0] seed;
   int          errors, n_tests;
   wire  [3:0]  outs = {pair4_out_a, pair3_out_a, pair2_out_a, pair1_out_a};
   assign {pair4_select_hi, pair4_select_lo, pair3_select_hi, pair3_select_lo,
           pair2_select_hi, pair2_select_lo, pair1_select_hi, pair1_select_lo} = straps;
   scof_core  scof_core_inst (.*);
   scof_board scof_board_inst (.clk(clk), .ref_hp(ref_hp), .fb_sel(fb_sel), .outs_a(outs),
      .reference_in(reference_in), .loop_feedback_in(loop_feedback_in));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // loop settling dominates the run time
   initial begin
      #3000000;
      errors++;
      close_out;
   end
   task close_out;
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input int e, input int g);
      n_tests++;
      if (g > e + 2 || g + 2 < e) begin
         errors++;
         $display("Error %0t exp %h got %h", $time, e, g);
      end
   endtask
   function automatic logic [3:0] rnd_skew();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return {2'(seed[7:0] % 3), 2'(seed[15:8] % 3)};
   endfunction
   // rate divisor of a pair three or four strap setting
   function automatic int divr(input logic [3:0] s);
      case (s)
         {`SCOF_LVL_LOW, `SCOF_LVL_LOW}: return 2;
         {`SCOF_LVL_LOW, `SCOF_LVL_HIGH}: return 4;
         default: return 1;
      endcase
   endfunction
   // window edges cost one count each side, hence the slack in check
   task automatic run(input logic [15:0] s, input logic [1:0] f, b, input logic [7:0] h);
      int rc = 0, nl = 0, hits = 0, since = 99;
      int c[4] = '{0, 0, 0, 0};
      int d[4] = '{1, 1, divr(s[11:8]), divr(s[15:12])};
      logic [3:0] pv = 4'h0;
      logic pr = 1'b1;
      logic lv = !(b == 2'h3 && s[15:12] == 4'ha);
      @(posedge clk);
      srst <= 1'b1;
      straps <= s;
      frequency_range_select <= f;
      fb_sel <= b;
      ref_hp <= h;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      repeat (6000) @(posedge clk);
      repeat (2400) begin
         @(negedge clk);
         since = (reference_in && !pr) ? 0 : since + 1;
         rc += (since == 0);
         if (since == 4) begin
            nl++;
            hits += (pair1_out_a === lv);
         end
         for (int k = 0; k < 4; k++) c[k] += (outs[k] && !pv[k]);
         pr = reference_in;
         pv = outs;
      end
      for (int k = 0; k < 4; k++) check(rc * d[b] / d[k], c[k]);
      check(nl, hits);
      n_tests++;
      if (loop_locked !== 1'b1) begin
         errors++;
         $display("Error %0t exp %h got %h", $time, 1'b1, loop_locked);
      end
   endtask
   initial begin
      srst = 1'b1;
      straps = 16'h5555;
      frequency_range_select = 2'h0;
      fb_sel = 2'h0;
      ref_hp = 8'h14;
      seed = 32'h51b8ec12;
      errors = 0;
      n_tests = 0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      run({8'h55, rnd_skew(), 4'h5}, 2'h0, 2'h0, 8'h20);
      run({8'ha5, rnd_skew(), 4'h5}, 2'h0, 2'h3, 8'h14);
      run({8'h02, rnd_skew(), 4'h5}, 2'h2, 2'h2, 8'h30);
      run({8'h05, rnd_skew(), 4'h5}, 2'h1, 2'h3, 8'h1c);
      run(16'h0255, 2'h0, 2'h1, 8'h10);
      close_out;
   end
endmodule
bind scof_core scof_properties scof_properties_inst (.*);
